/* File: pkg/lcdirq_cfg.svh */
// register map, field positions and reset values of the lcd irq block
`ifndef LCDIRQ_CFG_SVH
`define LCDIRQ_CFG_SVH
`define LCDIRQ_ADDR_W 12
`define LCDIRQ_OFF_CTRL 12'h000
`define LCDIRQ_OFF_STAT 12'h004
`define LCDIRQ_OFF_CLR 12'h008
`define LCDIRQ_OFF_IEN 12'h00C
`define LCDIRQ_OFF_STATE 12'h010
`define LCDIRQ_CTRL_EN 0
`define LCDIRQ_CTRL_DDM 1
`define LCDIRQ_CTRL_BASE_MASK 2
`define LCDIRQ_CTRL_ERR_MASK 3
`define LCDIRQ_CTRL_MODE_LO 4
`define LCDIRQ_CTRL_RST 6'h00
`define LCDIRQ_ST_DD 0
`define LCDIRQ_ST_BASE 1
`define LCDIRQ_ST_ERR_LO 2
`define LCDIRQ_ST_W 11
`define LCDIRQ_IEN_RST 11'h7FF
`define LCDIRQ_MODE_MONO_DUAL 2'h0
`define LCDIRQ_MODE_COLOR_SINGLE 2'h1
`define LCDIRQ_MODE_COLOR_DUAL 2'h2
`define LCDIRQ_MONO_LAST 3'h3
`define LCDIRQ_COLOR_LAST 3'h7
`endif

/* File: pkg/lcdirq_pkg.sv */
// types of the lcd irq block
package lcdirq_pkg;
    typedef enum logic [1:0] {
        LCDIRQ_IDLE,
        LCDIRQ_RUN,
        LCDIRQ_DRAIN
    } lcdirq_state_e;
    typedef logic [10:0] lcdirq_stat_t;
endpackage

/* File: core/lcdirq_top.sv */
// lcd interrupt gating, disable sequencing and passive pixel-to-pin ordering
//
// Contract
// - disable-done flag sets only after disable and current frame completes
// - disable-done mask clear: set disable-done flag raises request
// - disable-done mask set: disable-done flag gives no request
// - disable-done mask never changes the flag or its set/clear
// - frame start with base pointer copy sets base-update flag
// - base-update mask clear: set base-update flag raises request
// - base-update mask set: base-update flag gives no request
// - base-update mask never changes the flag or its set/clear
// - error group: bus error plus eight fifo overrun/underrun flags
// - error mask clear: any set error flag raises request
// - error mask set: all nine error flags give no request
// - error mask never changes error flags or their set/clear
// - mono dual: upper on pins 0-3, lower on 4-7, ascending
// - colour single: components on pins 7 down to 0, wrapping
// - colour dual: upper on pins 7-0, lower on gpio 7-0
// - enable cleared: finish current frame, then stop and set disable-done on the same edge
`timescale 1ns/1ns
`include "lcdirq_cfg.svh"

module lcdirq_top
    import lcdirq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic [8:0] err_evt,
    input wire logic comp_valid,
    input wire logic comp_upper,
    input wire logic comp_lower,
    output logic ctrl_active,
    output logic [7:0] panel_data_pins,
    output logic [7:0] gpio_data_pins,
    output logic pins_strobe,
    output logic irq
);

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_ctrl = (paddr == `LCDIRQ_OFF_CTRL);
    wire hit_stat = (paddr == `LCDIRQ_OFF_STAT);
    wire hit_clr = (paddr == `LCDIRQ_OFF_CLR);
    wire hit_ien = (paddr == `LCDIRQ_OFF_IEN);
    wire hit_state = (paddr == `LCDIRQ_OFF_STATE);
    wire mapped = hit_ctrl || hit_stat || hit_clr || hit_ien || hit_state;
    wire wr = access && pwrite && mapped;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_clr = wr && hit_clr;
    wire wr_ien = wr && hit_ien;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0] ctrl_q;
    logic [10:0] ien_q;
    lcdirq_stat_t stat_q;
    lcdirq_stat_t stat_d;
    lcdirq_state_e state_q;
    lcdirq_state_e state_d;
    logic [31:0] prdata_q;

    wire en_bit = ctrl_q[`LCDIRQ_CTRL_EN];
    wire disable_done_mask = ctrl_q[`LCDIRQ_CTRL_DDM];
    wire base_update_mask = ctrl_q[`LCDIRQ_CTRL_BASE_MASK];
    wire error_irq_mask = ctrl_q[`LCDIRQ_CTRL_ERR_MASK];
    wire [1:0] mode = ctrl_q[`LCDIRQ_CTRL_MODE_LO +: 2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LCDIRQ_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q <= `LCDIRQ_IEN_RST;
        end else if (wr_ien) begin
            ien_q <= pwdata[10:0];
        end
    end

    // ----------------------------------------
    // enable and disable sequencing
    // ----------------------------------------
    wire drain_done = (state_q == LCDIRQ_DRAIN) && frame_end;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LCDIRQ_IDLE: begin
                if (en_bit) begin
                    state_d = LCDIRQ_RUN;
                end
            end
            LCDIRQ_RUN: begin
                if (!en_bit) begin
                    state_d = LCDIRQ_DRAIN;
                end
            end
            LCDIRQ_DRAIN: begin
                if (frame_end) begin
                    state_d = LCDIRQ_IDLE;
                end
            end
            default: begin
                state_d = LCDIRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= LCDIRQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign ctrl_active = (state_q != LCDIRQ_IDLE);

    // ----------------------------------------
    // sticky status, set wins over clear
    // ----------------------------------------
    lcdirq_stat_t set_evt;
    assign set_evt[`LCDIRQ_ST_DD] = drain_done;
    assign set_evt[`LCDIRQ_ST_BASE] = frame_start && ctrl_active;
    assign set_evt[10:2] = err_evt;

    wire [10:0] clr_bits = wr_clr ? pwdata[10:0] : 11'h000;
    assign stat_d = (stat_q & ~clr_bits) | set_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 11'h000;
        end else begin
            stat_q <= stat_d;
        end
    end

    // ----------------------------------------
    // request gating
    // ----------------------------------------
    wire [10:0] grp_open = {{9{!error_irq_mask}}, !base_update_mask, !disable_done_mask};
    wire [10:0] pend = stat_q & ien_q & grp_open;
    wire dd_req = pend[0];
    wire base_req = pend[1];
    wire err_req = |pend[10:2];
    assign irq = dd_req || base_req || err_req;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_q} :
        hit_stat ? {21'h0, stat_q} :
        hit_ien ? {21'h0, ien_q} :
        hit_state ? {30'h0, state_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_mux;
        end
    end

    assign prdata = prdata_q;

    // ----------------------------------------
    // pixel-to-pin ordering
    // ----------------------------------------
    logic [2:0] pos_q;
    logic [7:0] sh_pins_q;
    logic [7:0] sh_gpio_q;
    logic [7:0] pins_q;
    logic [7:0] gpio_q;
    logic strobe_q;

    // pin index for a component position
    function automatic logic [2:0] pin_idx(input logic [2:0] p, input logic up, input logic mono);
        logic [2:0] r;
        r = mono ? (up ? p : p + 3'h4) : 3'h7 - p;
        return r;
    endfunction

    wire is_mono = (mode == `LCDIRQ_MODE_MONO_DUAL);
    wire is_dual = (mode != `LCDIRQ_MODE_COLOR_SINGLE);
    wire take = comp_valid && ctrl_active;
    wire [2:0] last = is_mono ? `LCDIRQ_MONO_LAST : `LCDIRQ_COLOR_LAST;
    wire word_done = take && (pos_q == last);
    wire [2:0] up_at = pin_idx(pos_q, 1'b1, is_mono);
    wire [2:0] lo_at = pin_idx(pos_q, 1'b0, is_mono);

    logic [7:0] pins_n;
    logic [7:0] gpio_n;
    always_comb begin
        pins_n = sh_pins_q;
        gpio_n = sh_gpio_q;
        pins_n[up_at] = comp_upper;
        if (is_mono) begin
            pins_n[lo_at] = comp_lower;
        end else if (is_dual) begin
            gpio_n[lo_at] = comp_lower;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 3'h0;
        end else if (!ctrl_active || word_done) begin
            pos_q <= 3'h0;
        end else if (take) begin
            pos_q <= pos_q + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_pins_q <= 8'h00;
            sh_gpio_q <= 8'h00;
        end else if (take) begin
            sh_pins_q <= pins_n;
            sh_gpio_q <= gpio_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= 8'h00;
            gpio_q <= 8'h00;
        end else if (word_done) begin
            pins_q <= pins_n;
            gpio_q <= gpio_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= word_done;
        end
    end

    assign panel_data_pins = pins_q;
    assign gpio_data_pins = gpio_q;
    assign pins_strobe = strobe_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_dd_cause;
        $rose(stat_q[0]) |-> $past(state_q == LCDIRQ_DRAIN && frame_end);
    endproperty
    a_dd_cause: assert property (p_dd_cause) else $error("disable-done set without drain end");

    property p_dd_set;
        (state_q == LCDIRQ_DRAIN && frame_end) |=> stat_q[0] && state_q == LCDIRQ_IDLE;
    endproperty
    a_dd_set: assert property (p_dd_set) else $error("disable-done not set at frame end");

    property p_dd_req;
        (stat_q[0] && ien_q[0] && !disable_done_mask) |-> irq;
    endproperty
    a_dd_req: assert property (p_dd_req) else $error("disable-done request missing");

    property p_irq_cause;
        irq |-> (stat_q[0] && ien_q[0] && !disable_done_mask) || (stat_q[1] && ien_q[1] && !base_update_mask)
            || ((|(stat_q[10:2] & ien_q[10:2])) && !error_irq_mask);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request from masked source");

    property p_base_set;
        (frame_start && ctrl_active) |=> stat_q[1];
    endproperty
    a_base_set: assert property (p_base_set) else $error("base-update flag not set");

    property p_base_req;
        (stat_q[1] && ien_q[1] && !base_update_mask) |-> irq;
    endproperty
    a_base_req: assert property (p_base_req) else $error("base-update request missing");

    property p_err_set;
        (|err_evt) |=> ((stat_q[10:2] & $past(err_evt)) == $past(err_evt));
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not set");

    property p_err_req;
        (|(stat_q[10:2] & ien_q[10:2]) && !error_irq_mask) |-> irq;
    endproperty
    a_err_req: assert property (p_err_req) else $error("error request missing");

    property p_dd_masked;
        (disable_done_mask && stat_q[10:1] == 10'h000) |-> !irq;
    endproperty
    a_dd_masked: assert property (p_dd_masked) else $error("masked disable-done raised request");

    property p_base_masked;
        (base_update_mask && !stat_q[0] && stat_q[10:2] == 9'h000) |-> !irq;
    endproperty
    a_base_masked: assert property (p_base_masked) else $error("masked base-update raised request");

    property p_err_masked;
        (error_irq_mask && stat_q[1:0] == 2'b00) |-> !irq;
    endproperty
    a_err_masked: assert property (p_err_masked) else $error("masked error raised request");

    property p_flag_hold;
        (!wr_clr && set_evt == 11'h000) |=> $stable(stat_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("status changed without event or clear");

    property p_base_idle;
        (frame_start && !ctrl_active && !stat_q[1]) |=> !stat_q[1];
    endproperty
    a_base_idle: assert property (p_base_idle) else $error("base-update set while idle");

    property p_mono_pins;
        (word_done && is_mono) |=> pins_strobe && panel_data_pins[3] == $past(comp_upper)
            && panel_data_pins[7] == $past(comp_lower);
    endproperty
    a_mono_pins: assert property (p_mono_pins) else $error("mono dual pin order wrong");

    property p_color_pins;
        (word_done && !is_mono) |=> panel_data_pins[0] == $past(comp_upper);
    endproperty
    a_color_pins: assert property (p_color_pins) else $error("colour pin order wrong");

    property p_dual_gpio;
        (word_done && is_dual && !is_mono) |=> gpio_data_pins[0] == $past(comp_lower);
    endproperty
    a_dual_gpio: assert property (p_dual_gpio) else $error("colour dual gpio order wrong");

    property p_drain;
        (state_q == LCDIRQ_RUN && !en_bit) |=> state_q == LCDIRQ_DRAIN;
    endproperty
    c_drain: cover property (p_drain);

    property p_masked_err;
        stat_q[2] && error_irq_mask && !irq;
    endproperty
    c_masked_err: cover property (p_masked_err);

    property p_word;
        word_done && is_dual ##1 pins_strobe;
    endproperty
    c_word: cover property (p_word);

    property p_base_irq;
        stat_q[1] && irq && !base_update_mask;
    endproperty
    c_base_irq: cover property (p_base_irq);

endmodule

/* File: test/lcdirq_panel_model.sv */
// panel-side receiver model of the lcd irq block
`timescale 1ns/1ns

module lcdirq_panel_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pins_strobe,
    input wire logic [7:0] panel_data_pins,
    input wire logic [7:0] gpio_data_pins,
    output logic [7:0] seen_panel,
    output logic [7:0] seen_gpio,
    output logic [7:0] words
);
    // ----------------------------------------
    // latch each completed pin word
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_panel <= 8'h00;
            seen_gpio <= 8'h00;
            words <= 8'h00;
        end else if (pins_strobe) begin
            seen_panel <= panel_data_pins;
            seen_gpio <= gpio_data_pins;
            words <= words + 8'h01;
        end
    end
endmodule

/* File: test/lcd_irq_mask_and_pin_order_bench.sv */
// self-checking bench of the lcd irq block
`timescale 1ns/1ns
`include "lcdirq_cfg.svh"

module lcd_irq_mask_and_pin_order_bench
    import lcdirq_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [11:0] CTL = `LCDIRQ_OFF_CTRL;
    localparam logic [11:0] STA = `LCDIRQ_OFF_STAT;
    localparam logic [11:0] CLR = `LCDIRQ_OFF_CLR;
    localparam logic [11:0] IEN = `LCDIRQ_OFF_IEN;
    localparam logic [11:0] STE = `LCDIRQ_OFF_STATE;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic frame_start = 1'h0, frame_end = 1'h0, comp_valid = 1'h0, comp_upper = 1'h0, comp_lower = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [8:0] err_evt = 9'h000, v;
    logic pready, pslverr, ctrl_active, pins_strobe, irq, er;
    logic [7:0] panel_data_pins, gpio_data_pins, ub, lb, sp, sg, words;
    int bad_count = 0, n_compared = 0, seed = 32'h729d, n;

    always #20 pclk = ~pclk;

    lcdirq_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .frame_start, .frame_end, .err_evt, .comp_valid, .comp_upper, .comp_lower, .ctrl_active,
        .panel_data_pins, .gpio_data_pins, .pins_strobe, .irq);
    lcdirq_panel_model panel (.pclk, .presetn, .pins_strobe, .panel_data_pins, .gpio_data_pins,
        .seen_panel(sp), .seen_gpio(sg), .words);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge pclk);
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask

    task ev(input logic fs, input logic fe, input logic [8:0] e);
        @(posedge pclk);
        frame_start <= fs;
        frame_end <= fe;
        err_evt <= e;
        @(posedge pclk);
        frame_start <= 1'h0;
        frame_end <= 1'h0;
        err_evt <= 9'h000;
        @(negedge pclk);
    endtask

    function automatic logic [7:0] rev(input logic [7:0] x);
        for (int i = 0; i < 8; i++) begin
            rev[i] = x[7-i];
        end
    endfunction

    function automatic logic [7:0] exp_p(input int md, input logic [7:0] u, input logic [7:0] l);
        exp_p = (md == 0) ? {l[3:0], u[3:0]} : rev(u);
    endfunction

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        #800000;
        bad_count++;
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        chk(pready, 32'h1);
        rdc(CTL, 32'h0);
        rdc(IEN, 32'h7FF);
        rdc(STA, 32'h0);
        apb(1'h0, 12'h020, 32'h0);
        chk(er, 32'h1);
        apb(1'h1, STA, 32'h7FF);
        rdc(STA, 32'h0);
        for (int m = 0; m < 2; m++) begin
            apb(1'h1, CTL, 32'h1 | (m << 2));
            ev(1'h1, 1'h0, 9'h000);
            rdc(STA, 32'h2);
            chk(irq, m == 0);
            apb(1'h1, CLR, 32'h2);
            rdc(STA, 32'h0);
        end
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 10; i++) begin
                v = (i < 9) ? (9'h001 << i) : (9'($random(seed)) | 9'h001);
                apb(1'h1, CTL, 32'h1 | (m << 3));
                ev(1'h0, 1'h0, v);
                rdc(STA, {21'h0, v, 2'h0});
                chk(irq, m == 0);
                if (m == 0 && i == 0) begin
                    apb(1'h1, IEN, 32'h0);
                    chk(irq, 32'h0);
                    apb(1'h1, IEN, 32'h7FF);
                end
                apb(1'h1, CLR, 32'h7FF);
                rdc(STA, 32'h0);
            end
        end
        for (int md = 0; md < 4; md++) begin
            apb(1'h1, CTL, 32'hF | (md << 4));
            ub = 8'($random(seed));
            lb = 8'($random(seed));
            for (int k = 0; k < ((md == 0) ? 4 : 8); k++) begin
                @(posedge pclk);
                comp_valid <= 1'h1;
                comp_upper <= ub[k];
                comp_lower <= lb[k];
            end
            @(posedge pclk);
            comp_valid <= 1'h0;
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (pins_strobe !== 1'h1 && n < 10);
            chk(n, 32'h1);
            @(negedge pclk);
            chk(sp, exp_p(md, ub, lb));
            if (md >= 2) begin
                chk(sg, rev(lb));
            end
        end
        chk(words, 32'h4);
        for (int m = 0; m < 2; m++) begin
            apb(1'h1, CTL, 32'h1);
            apb(1'h1, CLR, 32'h7FF);
            apb(1'h1, CTL, m << 1);
            chk(ctrl_active, 32'h1);
            rdc(STE, 32'h2);
            rdc(STA, 32'h0);
            ev(1'h0, 1'h1, 9'h000);
            chk(ctrl_active, 32'h0);
            rdc(STE, 32'h0);
            ev(1'h1, 1'h0, 9'h000);
            rdc(STA, 32'h1);
            chk(irq, m == 0);
            apb(1'h1, CLR, 32'h1);
            rdc(STA, 32'h0);
        end
        apb(1'h1, IEN, 32'h0);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rdc(IEN, 32'h7FF);
        rdc(CTL, 32'h0);
        rdc(STA, 32'h0);
        test_done();
    end
endmodule
